/* src/rsse_map.vh */
`ifndef RSSE_MAP_VH
`define RSSE_MAP_VH
// Opcode patterns
`define RSSE_OP_ROT_HI 6'h10
`define RSSE_OP_SET_HI 7'h34
`define RSSE_OP_HALT 16'h0003
// Register byte addresses
`define RSSE_A_INSTR 8'h00
`define RSSE_A_CTRL 8'h04
`define RSSE_A_STAT 8'h08
`define RSSE_A_WREG 8'h0C
`define RSSE_A_MEMADDR 8'h10
`define RSSE_A_MEMDATA 8'h14
`define RSSE_A_BANK 8'h18
`define RSSE_A_WDT 8'h1C
// Status bits
`define RSSE_ST_BUSY 0
`define RSSE_ST_HALT 1
`define RSSE_ST_TO 2
`define RSSE_ST_PD 3
`define RSSE_ST_N 4
`define RSSE_ST_Z 5
// Reset values
`define RSSE_RST_TO 1'b1
`define RSSE_RST_PD 1'b1
// Access bank split
`define RSSE_ACC_SPLIT 8'h80
`define RSSE_ACC_HIBANK 4'hF
// Phases
`define RSSE_PH_IDLE 3'h0
`define RSSE_PH_Q1 3'h1
`define RSSE_PH_Q2 3'h2
`define RSSE_PH_Q3 3'h3
`define RSSE_PH_Q4 3'h4
`endif

/* src/rsse_core.v */
`timescale 1ns/1ps
module rsse_core #(
	parameter AW = 12,
	parameter POSTW = 8
) (
	hclk,
	hresetn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hresp,
	hrdata,
	wake_wdt,
	wake_other,
	osc_run,
	timeout_flag,
	powerdown_flag
);
`include "rsse_map.vh"
	input wire hclk;
	input wire hresetn;
	input wire hsel;
	input wire [31:0] haddr;
	input wire [1:0] htrans;
	input wire hwrite;
	input wire [2:0] hsize;
	input wire [31:0] hwdata;
	input wire hready;
	output reg hreadyout;
	output reg hresp;
	output reg [31:0] hrdata;
	input wire wake_wdt;
	input wire wake_other;
	output reg osc_run;
	output reg timeout_flag;
	output reg powerdown_flag;

	reg [7:0] mem_q [0:(1<<AW)-1];
	reg [15:0] instr_q;
	reg [2:0] ph_q;
	reg halt_q;
	reg [7:0] wreg_q;
	reg [3:0] bank_select_register_q;
	reg [7:0] watchdog_counter_q;
	reg [POSTW-1:0] post_q;
	reg n_q;
	reg z_q;
	reg [AW-1:0] ea_q;
	reg [7:0] opnd_q;
	reg [7:0] res_q;
	reg [AW-1:0] maddr_q;
	reg wk_s1_q;
	reg wk_s2_q;
	reg wo_s1_q;
	reg wo_s2_q;
	reg ap_q;
	reg ap_wr_q;
	reg [7:0] ap_addr_q;

	wire rotate_right_nocarry_op = instr_q[15:10] == `RSSE_OP_ROT_HI;
	wire set_all_ones_op = instr_q[15:9] == `RSSE_OP_SET_HI;
	wire halt_op = instr_q == `RSSE_OP_HALT;

	// Rotate right by one, bit 0 wraps into bit 7
	function [7:0] rotr1;
		input [7:0] v;
		begin
			rotr1 = {v[0], v[7:1]};
		end
	endfunction

	// Effective address from access bit, bank and file field
	function [AW-1:0] eff_addr;
		input abit;
		input [3:0] bank;
		input [7:0] f;
		begin
			if (!abit) begin
				if (f < `RSSE_ACC_SPLIT)
					eff_addr = {{(AW-8){1'b0}}, f};
				else
					eff_addr = {`RSSE_ACC_HIBANK, f};
			end else begin
				eff_addr = {bank, f};
			end
		end
	endfunction

	wire bus_ok = hsel && hready && htrans[1];
	wire busy = ph_q != `RSSE_PH_IDLE;
	wire [31:0] stat = {26'h0, z_q, n_q, powerdown_flag, timeout_flag, halt_q, busy};
	// Register writes land in the data phase, and only while no instruction runs
	wire reg_wr = ap_q && ap_wr_q && !busy;
	wire start = reg_wr && ap_addr_q == `RSSE_A_CTRL && hwdata[0] && !halt_q;
	wire q4 = ph_q == `RSSE_PH_Q4;
	wire halt_exec = q4 && halt_op;
	wire wake = halt_q && !busy && (wk_s2_q || wo_s2_q);
	reg [2:0] ph_d;
	reg [31:0] rdata_d;

	// One instruction cycle of four phases
	always @* begin
		ph_d = ph_q;
		case (ph_q)
		`RSSE_PH_IDLE: begin
			if (start)
				ph_d = `RSSE_PH_Q1;
		end
		`RSSE_PH_Q1: ph_d = `RSSE_PH_Q2;
		`RSSE_PH_Q2: ph_d = `RSSE_PH_Q3;
		`RSSE_PH_Q3: ph_d = `RSSE_PH_Q4;
		`RSSE_PH_Q4: ph_d = `RSSE_PH_IDLE;
		default: ph_d = `RSSE_PH_IDLE;
		endcase
	end

	always @* begin
		rdata_d = 32'h00000000;
		case (haddr[7:0])
		`RSSE_A_INSTR: rdata_d = {16'h0000, instr_q};
		`RSSE_A_STAT: rdata_d = stat;
		`RSSE_A_WREG: rdata_d = {24'h000000, wreg_q};
		`RSSE_A_MEMADDR: rdata_d = {{(32-AW){1'b0}}, maddr_q};
		`RSSE_A_MEMDATA: rdata_d = {24'h000000, mem_q[maddr_q]};
		`RSSE_A_BANK: rdata_d = {28'h0000000, bank_select_register_q};
		`RSSE_A_WDT: rdata_d = {24'h000000, watchdog_counter_q};
		default: rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wk_s1_q <= 1'b0;
			wk_s2_q <= 1'b0;
			wo_s1_q <= 1'b0;
			wo_s2_q <= 1'b0;
		end else begin
			wk_s1_q <= wake_wdt;
			wk_s2_q <= wk_s1_q;
			wo_s1_q <= wake_other;
			wo_s2_q <= wo_s1_q;
		end
	end

	// Instruction write-back has priority over a bus preload
	always @(posedge hclk) begin
		if (q4 && (set_all_ones_op || (rotate_right_nocarry_op && instr_q[9])))
			mem_q[ea_q] <= res_q;
		else if (reg_wr && ap_addr_q == `RSSE_A_MEMDATA)
			mem_q[maddr_q] <= hwdata[7:0];
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ph_q <= `RSSE_PH_IDLE;
		else
			ph_q <= ph_d;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ap_q <= 1'b0;
			ap_wr_q <= 1'b0;
			ap_addr_q <= 8'h00;
		end else begin
			// Zero wait states: every transfer ends in its data phase
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			ap_q <= bus_ok;
			if (bus_ok) begin
				ap_wr_q <= hwrite;
				ap_addr_q <= haddr[7:0];
			end
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (bus_ok && !hwrite)
			hrdata <= rdata_d;
		else
			hrdata <= 32'h00000000;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_q <= 16'h0000;
			wreg_q <= 8'h00;
			maddr_q <= {AW{1'b0}};
			bank_select_register_q <= 4'h0;
		end else begin
			if (reg_wr) begin
				case (ap_addr_q)
				`RSSE_A_INSTR: instr_q <= hwdata[15:0];
				`RSSE_A_WREG: wreg_q <= hwdata[7:0];
				`RSSE_A_MEMADDR: maddr_q <= hwdata[AW-1:0];
				`RSSE_A_BANK: bank_select_register_q <= hwdata[3:0];
				default: ;
				endcase
			end
			if (q4 && rotate_right_nocarry_op && !instr_q[9])
				wreg_q <= res_q;
		end
	end

	// Operand path: address in Q1, read in Q2, process in Q3
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ea_q <= {AW{1'b0}};
			opnd_q <= 8'h00;
			res_q <= 8'h00;
		end else begin
			if (ph_q == `RSSE_PH_Q1)
				ea_q <= eff_addr(instr_q[8], bank_select_register_q, instr_q[7:0]);
			if (ph_q == `RSSE_PH_Q2)
				opnd_q <= mem_q[ea_q];
			if (ph_q == `RSSE_PH_Q3)
				res_q <= set_all_ones_op ? 8'hFF : rotr1(opnd_q);
		end
	end

	// Only the rotate touches N and Z; set-all-ones leaves them alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			n_q <= 1'b0;
			z_q <= 1'b0;
		end else if (q4 && rotate_right_nocarry_op) begin
			n_q <= res_q[7];
			z_q <= res_q == 8'h00;
		end
	end

	// Watchdog counts only while the oscillator runs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_counter_q <= 8'h00;
			post_q <= {POSTW{1'b0}};
		end else if (halt_exec) begin
			watchdog_counter_q <= 8'h00;
			post_q <= {POSTW{1'b0}};
		end else if (osc_run) begin
			post_q <= post_q + 1'b1;
			if (&post_q)
				watchdog_counter_q <= watchdog_counter_q + 8'h01;
		end
	end

	// Halt entry and wake; the two never meet since wake needs an idle core
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_q <= 1'b0;
			osc_run <= 1'b1;
			timeout_flag <= `RSSE_RST_TO;
			powerdown_flag <= `RSSE_RST_PD;
		end else if (halt_exec) begin
			powerdown_flag <= 1'b0;
			timeout_flag <= 1'b1;
			halt_q <= 1'b1;
			osc_run <= 1'b0;
		end else if (wake) begin
			halt_q <= 1'b0;
			osc_run <= 1'b1;
			if (wk_s2_q)
				timeout_flag <= 1'b0;
		end
	end
endmodule

/* testbench/rsse_monitor.sv */
`timescale 1ns/1ps
module rsse_monitor (
	input wire hclk,
	input wire hresetn,
	input wire wake_wdt,
	input wire osc_run,
	input wire timeout_flag,
	input wire powerdown_flag
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_halt;
		$fell(osc_run);
	endsequence
	sequence s_wake;
		$fell(timeout_flag);
	endsequence
	a_halt_flags: assert property (s_halt |-> timeout_flag && !powerdown_flag)
		else $error("halt flags wrong");
	a_pd_at_halt: assert property ($fell(powerdown_flag) |-> s_halt)
		else $error("power-down flag cleared outside halt");
	a_to_at_halt: assert property ($rose(timeout_flag) |-> s_halt)
		else $error("timeout flag set outside halt");
	a_four_phases: assert property (s_halt |-> $past(osc_run, 4))
		else $error("halt came too soon");
	a_halt_holds: assert property (s_halt ##0 !wake_wdt |=> !osc_run)
		else $error("oscillator restarted without wake");
	a_wake_bound: assert property ((!osc_run && wake_wdt) [*3] |=> osc_run)
		else $error("watchdog wake too slow");
	a_wake_to: assert property (s_wake |-> $rose(osc_run))
		else $error("timeout flag cleared outside wake");
	a_wake_clears: assert property ($rose(osc_run) ##0 $past(wake_wdt) |-> !timeout_flag)
		else $error("watchdog wake kept timeout flag");
endmodule
bind rsse_core rsse_monitor u_rsse_monitor (.*);

/* testbench/test_rotate_set_sleep_exec.sv */
`timescale 1ns/1ps
`include "rsse_map.vh"
module test_rotate_set_sleep_exec;
	reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, wake_wdt = 0;
	reg [31:0] haddr = 0, hwdata = 0, q;
	reg [1:0] htrans = 0;
	wire hready, hresp, osc_run, timeout_flag, powerdown_flag;
	wire [31:0] hrdata;
	integer failures = 0, comparisons = 0, cyc = 0, i;
	// Row: opcode, memory address, preload, bank, read-back address, result, {Z,N}
	reg [63:0] rows [0:4];
	rsse_core u_rsse_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .wake_wdt(wake_wdt),
		.wake_other(1'b0), .osc_run(osc_run), .timeout_flag(timeout_flag),
		.powerdown_flag(powerdown_flag));
	always #50 hclk = ~hclk;
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			results;
		end
	end
	task chk(input [8*8-1:0] name, input [31:0] e, input [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("ERROR %0s expected %h seen %h", name, e, g);
		end
	endtask
	task bus(input [7:0] a, input w, input [31:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task run(input [15:0] op);
		bus(`RSSE_A_INSTR, 1, {16'h0, op});
		bus(`RSSE_A_CTRL, 1, 32'h1);
		q = 1;
		while (q[0] !== 1'b0) bus(`RSSE_A_STAT, 0, 0);
	endtask
	initial begin
		rows[0] = 64'h4025_0025_D7_0_0C_EB_1;
		rows[1] = 64'h4025_0025_00_0_0C_00_2;
		rows[2] = 64'h6890_0F90_5A_2_14_FF_2;
		rows[3] = 64'h4325_0325_01_3_14_80_1;
		rows[4] = 64'h6910_0510_33_5_14_FF_1;
		repeat (12) @(posedge hclk);
		chk("resetval", 32'h7, {osc_run, timeout_flag, powerdown_flag});
		hresetn <= 1;
		@(posedge hclk);
		for (i = 0; i < 5; i = i + 1) begin
			bus(`RSSE_A_MEMADDR, 1, rows[i][47:32]);
			bus(`RSSE_A_MEMDATA, 1, rows[i][31:24]);
			bus(`RSSE_A_BANK, 1, rows[i][23:20]);
			run(rows[i][63:48]);
			chk("nzflags", rows[i][1:0], q[5:4]);
			bus(`RSSE_A_MEMADDR, 1, rows[i][47:32]);
			bus(rows[i][19:12], 0, 0);
			chk("result", rows[i][11:4], q);
			$display("row %0d done", i);
		end
		run(`RSSE_OP_HALT);
		chk("haltpins", 32'h2, {osc_run, timeout_flag, powerdown_flag});
		bus(`RSSE_A_WDT, 0, 0);
		chk("wdt", 32'h0, q);
		$display("halt done");
		wake_wdt <= 1;
		repeat (6) @(posedge hclk);
		chk("wakepins", 32'h4, {osc_run, timeout_flag, powerdown_flag});
		$display("wake done");
		results;
	end
endmodule
